// ### hdl/dpscp_port.sv
// Serial control port: SPI and two-wire slave, write FIFO
`timescale 1ns/100ps
`include "dpscp_defs.svh"

module dpscp_fifo #(
  parameter int W = 24,
  parameter int D = 8
) (
  input wire logic i_core_clk,
  input wire logic i_reset,
  input wire logic i_clk_en,
  input wire logic i_valid,
  output logic o_ready,
  input wire logic [W-1:0] i_data,
  output logic o_valid,
  input wire logic i_ready,
  output logic [W-1:0] o_data
);
  localparam int AW = $clog2(D);
  typedef struct packed {
    logic [D-1:0][W-1:0] mem;
    logic [AW:0] wp;
    logic [AW:0] rp;
  } dpscp_fst_t;
  dpscp_fst_t q, d;
  logic full, empty;
  assign empty = (q.wp == q.rp);
  assign full = (q.wp[AW] != q.rp[AW]) && (q.wp[AW-1:0] == q.rp[AW-1:0]);
  assign o_ready = !full;
  assign o_valid = !empty;
  assign o_data = q.mem[q.rp[AW-1:0]];
  always_comb begin
    d = q;
    if (i_valid && !full) begin
      d.mem[q.wp[AW-1:0]] = i_data;
      d.wp = q.wp + 1'b1;
    end
    if (i_ready && !empty) begin
      d.rp = q.rp + 1'b1;
    end
  end
  always_ff @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset) begin
      q <= '0;
    end else if (i_clk_en) begin
      q <= d;
    end
  end
endmodule

// What this block does
// - Both direction bits zero: SPI address decrements; two-wire address always increments
// - Both direction bits one: address increments
// - Read shifts N bytes over N*8 clocks
// - Readback changes on falling, sampled rising
// - Streamed read returns every address, none skipped
// - Read source bit picks buffered or active
// - Instruction: read/write flag, 15-bit address
// - Default MSB first; bit-order write switches immediately
// - Two-wire: slave only, clock never driven
// - Two-wire write: 16-bit address, high first
// - Address byte: 7-bit address plus direction
// - Answer only own slave address
// - Receiver acknowledges by low ninth pulse
// - After no-acknowledge, return to idle
// - Host no-acknowledge ends read, release line
// - Bytes are eight bits, MSB first, acknowledged
// - Data changes with clock low; start, stop
// - Start or stop anywhere discards partial byte
// - Unlimited data bytes per transfer
// - Two-wire read returns data from current address
// - Port-select pins pick protocol and address
// - Chip select high releases data pin
// - Instruction on first 16 rising edges
// - Update bit copies buffered to active, clears
module dpscp_port
  import dpscp_pkg::*;
(
  input wire logic i_core_clk,
  input wire logic i_reset,
  input wire logic i_clk_en,
  input wire logic [1:0] i_port_select_pin_0,
  input wire logic [1:0] i_port_select_pin_1,
  input wire logic i_sclk,
  input wire logic i_cs_n,
  input wire logic i_sdio,
  output logic o_sdio,
  output logic o_sdio_oe,
  output logic o_spi_mode,
  output logic o_wr_valid,
  input wire logic i_wr_ready,
  output dpscp_wr_t o_wr,
  output logic o_rd_req,
  output logic [15:0] o_rd_addr,
  input wire logic [7:0] i_rd_buf_data,
  input wire logic [7:0] i_rd_act_data,
  output logic o_io_update
);
  dpscp_st_t q, d;
  logic fifo_ir, fifo_ov;
  logic rise, fall, start, stop;

  // ****************************************
  // Write buffer
  // ****************************************
  dpscp_fifo #(.W(`DPSCP_WR_W), .D(`DPSCP_FIFO_DEPTH)) u_fifo (
    .i_core_clk(i_core_clk),
    .i_reset(i_reset),
    .i_clk_en(i_clk_en),
    .i_valid(q.wv),
    .o_ready(fifo_ir),
    .i_data(q.wd),
    .o_valid(fifo_ov),
    .i_ready(i_wr_ready),
    .o_data(o_wr)
  );

  assign o_wr_valid = fifo_ov;
  assign o_sdio = q.spi ? q.sdo : 1'b0;
  assign o_sdio_oe = q.oe;
  assign o_spi_mode = q.spi;
  assign o_rd_req = q.rd_req;
  assign o_rd_addr = q.rd_addr;
  assign o_io_update = q.upd;

  // Edges of the serial clock and two-wire conditions
  assign rise = q.sck_s && !q.sck_p;
  assign fall = !q.sck_s && q.sck_p;
  assign start = q.sck_s && q.sck_p && q.sd_p && !q.sd_s;
  assign stop = q.sck_s && q.sck_p && !q.sd_p && q.sd_s;

  // Pin code: floating 0, low 1, high 2
  function automatic logic [3:0] pin_code(input logic [1:0] p);
    pin_code = p[1] ? 4'h0 : (p[0] ? 4'h2 : 4'h1);
  endfunction

  function automatic logic [15:0] step(input dpscp_st_t s);
    step = s.asc ? ((s.addr + `DPSCP_ADDR_ONE) & `DPSCP_ADDR_MASK) : ((s.addr - `DPSCP_ADDR_ONE) & `DPSCP_ADDR_MASK);
  endfunction

  function automatic dpscp_st_t req_rd(input dpscp_st_t s);
    dpscp_st_t r;
    r = s;
    r.rd_req = 1'b1;
    r.rd_addr = s.addr;
    req_rd = r;
  endfunction

  // Register write: SPI config bytes and the update bit stay here
  function automatic dpscp_st_t reg_wr(input dpscp_st_t s, input logic [7:0] b, input logic rdy);
    dpscp_st_t r;
    r = s;
    if (s.spi && s.addr == `DPSCP_CFG_A) begin
      // bit order takes effect on the next bit
      r.lsb = b[`DPSCP_LSB_HI] | b[`DPSCP_LSB_LO];
      r.asc = b[`DPSCP_ASC_HI] & b[`DPSCP_ASC_LO];
    end else if (s.spi && s.addr == `DPSCP_CFG_B) begin
      r.rdbuf = b[`DPSCP_RDBUF_BIT];
    end else if (s.addr == `DPSCP_UPD_ADDR) begin
      r.upd_pend = s.upd_pend | b[`DPSCP_UPD_BIT];
    end else if (rdy) begin
      r.wv = 1'b1;
      r.wd = '{addr: s.addr, data: b};
    end
    reg_wr = r;
  endfunction

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    logic [15:0] nsr;
    logic [3:0] idx;
    logic plain;
    nsr = '0;
    idx = '0;
    plain = 1'b0;
    d = q;
    d.rd_req = 1'b0;
    d.upd = 1'b0;
    d.wv = 1'b0;
    d.rd_ld = q.rd_req;
    d.sp0_m = i_port_select_pin_0;
    d.sp0_s = q.sp0_m;
    d.sp1_m = i_port_select_pin_1;
    d.sp1_s = q.sp1_m;
    d.sck_m = i_sclk;
    d.sck_s = q.sck_m;
    d.sck_p = q.sck_s;
    d.cs_m = i_cs_n;
    d.cs_s = q.cs_m;
    d.sd_m = i_sdio;
    d.sd_s = q.sd_m;
    d.sd_p = q.sd_s;
    if (q.rd_ld) begin
      d.tx = q.rdbuf ? i_rd_buf_data : i_rd_act_data;
    end
    // straps caught once after reset release, held until next reset
    if (!q.act) begin
      if (q.scnt == `DPSCP_STRAP_WAIT) begin
        idx = pin_code(q.sp0_s) * 4'h3 + pin_code(q.sp1_s);
        d.act = 1'b1;
        d.spi = (idx == `DPSCP_SPI_IDX_A) || (idx == `DPSCP_SPI_IDX_B);
        d.sadr = `DPSCP_SADR_BASE + 7'(idx);
      end else begin
        d.scnt = q.scnt + 2'h1;
      end
    end
    // update waits until every buffered write has drained
    if (q.upd_pend && !fifo_ov && !q.wv) begin
      d.upd = 1'b1;
      d.upd_pend = 1'b0;
    end
    if (q.act && q.spi) begin
      nsr = q.lsb ? {q.sd_s, q.sr[15:1]} : {q.sr[14:0], q.sd_s};
      if (q.cs_s) begin
        d.sph = SPH_CMD;
        d.cnt = '0;
        d.oe = 1'b0;
      end else if (rise && q.sph != SPH_RD) begin
        d.sr = nsr;
        d.cnt = q.cnt + 5'h1;
        if (q.sph == SPH_CMD && q.cnt == `DPSCP_INSTR_LAST) begin
          // flag on top, 15-bit address below
          d.rw = nsr[15];
          d.addr = {1'b0, nsr[14:0]};
          d.cnt = '0;
          d.sph = nsr[15] ? SPH_RD : SPH_WR;
          if (nsr[15]) begin
            d = req_rd(d);
          end
        end else if (q.sph == SPH_WR && q.cnt == `DPSCP_BYTE_LAST) begin
          // Full FIFO drops the byte: the link cannot be stalled
          d = reg_wr(d, q.lsb ? nsr[15:8] : nsr[7:0], fifo_ir);
          d.addr = step(d);
          d.cnt = '0;
        end
      end else if (fall && q.sph == SPH_RD) begin
        d.oe = 1'b1;
        d.sdo = q.lsb ? q.tx[0] : q.tx[7];
        d.tx = q.lsb ? {1'b0, q.tx[7:1]} : {q.tx[6:0], 1'b0};
        d.cnt = q.cnt + 5'h1;
        if (q.cnt == `DPSCP_BYTE_LAST) begin
          // next byte from the adjacent address, up or down per the direction bits
          d.cnt = '0;
          d.addr = step(q);
          d = req_rd(d);
        end
      end
    end else if (q.act) begin
      // only the data line is ever driven
      if (start) begin
        d.ist = IS_ADDR;
        d.cnt = '0;
        d.oe = 1'b0;
      end else if (stop) begin
        d.ist = IS_IDLE;
        d.oe = 1'b0;
      end else begin
        unique case (q.ist)
          IS_IDLE: d.ist = IS_IDLE;
          IS_ADDR, IS_RX: begin
            if (rise && q.cnt[3:0] != `DPSCP_I2C_BITS) begin
              d.sr = {q.sr[14:0], q.sd_s};
              d.cnt = q.cnt + 5'h1;
            end else if (fall && q.cnt[3:0] == `DPSCP_I2C_BITS) begin
              if (q.ist == IS_ADDR) begin
                if (q.sr[7:1] == q.sadr) begin
                  d.rw = q.sr[0];
                  d.ibyte = '0;
                  d.oe = 1'b1;
                  d.ist = IS_ACK;
                  if (q.sr[0]) begin
                    d = req_rd(d);
                    d.addr = q.addr + `DPSCP_ADDR_ONE;
                  end
                end else begin
                  d.ist = IS_IDLE;
                end
              end else begin
                // address high byte then low byte
                plain = 1'b1;
                if (q.ibyte == 2'h0) begin
                  d.addr[15:8] = q.sr[7:0];
                end else if (q.ibyte == 2'h1) begin
                  d.addr[7:0] = q.sr[7:0];
                end else begin
                  plain = (q.addr == `DPSCP_UPD_ADDR) || fifo_ir;
                  // any count of bytes, address advancing
                  d = reg_wr(d, q.sr[7:0], fifo_ir);
                  d.addr = q.addr + `DPSCP_ADDR_ONE;
                end
                if (q.ibyte != 2'h2) begin
                  d.ibyte = q.ibyte + 2'h1;
                end
                // acknowledge, or refuse and go idle
                d.oe = plain;
                d.ist = plain ? IS_ACK : IS_IDLE;
              end
            end
          end
          IS_ACK: begin
            if (fall) begin
              d.cnt = '0;
              d.oe = 1'b0;
              d.ist = IS_RX;
              if (q.rw) begin
                d.oe = !q.tx[7];
                d.tx = {q.tx[6:0], 1'b0};
                d.cnt = 5'h1;
                d.ist = IS_TX;
              end
            end
          end
          IS_TX: begin
            if (fall) begin
              if (q.cnt[3:0] == `DPSCP_I2C_BITS) begin
                d.oe = 1'b0;
                d.ist = IS_TACK;
              end else begin
                d.oe = !q.tx[7];
                d.tx = {q.tx[6:0], 1'b0};
                d.cnt = q.cnt + 5'h1;
              end
            end
          end
          IS_TACK: begin
            if (rise) begin
              if (q.sd_s) begin
                d.ist = IS_IDLE;
              end else begin
                d = req_rd(d);
                d.addr = q.addr + `DPSCP_ADDR_ONE;
                d.ist = IS_ACK;
              end
            end
          end
          default: d.ist = IS_IDLE;
        endcase
      end
    end
  end

  always_ff @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset) begin
      q <= '0;
    end else if (i_clk_en) begin
      q <= d;
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_reset);
  sequence s_spi_rd_fall;
    q.spi && !q.cs_s && fall && q.sph == SPH_RD && i_clk_en;
  endsequence
  a_cs_release: assert property (q.act && q.spi && q.cs_s && i_clk_en |=> !o_sdio_oe)
    else $error("data pin driven while deselected");
  a_addr_dec: assert property ((s_spi_rd_fall and (q.cnt == `DPSCP_BYTE_LAST && !q.asc))
    |=> q.addr == (($past(q.addr) - `DPSCP_ADDR_ONE) & `DPSCP_ADDR_MASK))
    else $error("address did not decrement");
  a_addr_inc: assert property ((s_spi_rd_fall and (q.cnt == `DPSCP_BYTE_LAST && q.asc))
    |=> q.addr == (($past(q.addr) + `DPSCP_ADDR_ONE) & `DPSCP_ADDR_MASK) && o_rd_req)
    else $error("address did not increment");
  a_rd_source: assert property (q.rd_ld && i_clk_en
    |=> q.tx == ($past(q.rdbuf) ? $past(i_rd_buf_data) : $past(i_rd_act_data)))
    else $error("read data from wrong source");
  a_rd_drive: assert property (s_spi_rd_fall |=> o_sdio_oe && o_sdio == $past(q.lsb ? q.tx[0] : q.tx[7]))
    else $error("readback bit not driven on falling edge");
  a_start_any: assert property (q.act && !q.spi && start && i_clk_en |=> q.ist == IS_ADDR && q.cnt == '0)
    else $error("start not taken");
  a_addr_miss: assert property (q.act && !q.spi && q.ist == IS_ADDR && fall && !start && !stop && i_clk_en
    && q.cnt[3:0] == `DPSCP_I2C_BITS && q.sr[7:1] != q.sadr |=> q.ist == IS_IDLE && !o_sdio_oe)
    else $error("foreign address answered");
  a_nack_idle: assert property (q.act && !q.spi && q.ist == IS_TACK && rise && q.sd_s && !start && !stop
    && i_clk_en |=> q.ist == IS_IDLE && !o_sdio_oe)
    else $error("read not ended on no-acknowledge");
  a_ack_low: assert property (q.act && !q.spi && q.ist == IS_ACK && !q.rw |-> o_sdio_oe && !o_sdio)
    else $error("acknowledge slot not driven low");
  a_upd_pulse: assert property (o_io_update |-> !fifo_ov ##1 !o_io_update || !i_clk_en)
    else $error("update not a single pulse");
endmodule

// ### pkg/dpscp_defs.svh
// Constants of the dual protocol serial control port
`ifndef DPSCP_DEFS_SVH
`define DPSCP_DEFS_SVH
`define DPSCP_CFG_A 16'h0000
`define DPSCP_CFG_B 16'h0001
`define DPSCP_UPD_ADDR 16'h000F
`define DPSCP_LSB_HI 6
`define DPSCP_LSB_LO 1
`define DPSCP_ASC_HI 5
`define DPSCP_ASC_LO 2
`define DPSCP_RDBUF_BIT 5
`define DPSCP_UPD_BIT 0
`define DPSCP_ADDR_MASK 16'h7FFF
`define DPSCP_ADDR_ONE 16'h0001
`define DPSCP_INSTR_LAST 5'h0F
`define DPSCP_BYTE_LAST 5'h07
`define DPSCP_I2C_BITS 4'h8
`define DPSCP_SADR_BASE 7'h38
`define DPSCP_SPI_IDX_A 4'h0
`define DPSCP_SPI_IDX_B 4'h8
`define DPSCP_STRAP_WAIT 2'h2
`define DPSCP_FIFO_DEPTH 8
`define DPSCP_WR_W 24
`endif

// ### pkg/dpscp_pkg.sv
// Types of the dual protocol serial control port
package dpscp_pkg;
  typedef enum logic [1:0] {SPH_CMD, SPH_WR, SPH_RD} dpscp_sph_t;
  typedef enum logic [2:0] {IS_IDLE, IS_ADDR, IS_RX, IS_ACK, IS_TX, IS_TACK} dpscp_ist_t;
  typedef struct packed {
    logic [15:0] addr;
    logic [7:0] data;
  } dpscp_wr_t;
  typedef struct packed {
    logic [1:0] sp0_m, sp0_s, sp1_m, sp1_s;
    logic [1:0] scnt;
    logic act, spi;
    logic [6:0] sadr;
    logic sck_m, sck_s, sck_p, cs_m, cs_s, sd_m, sd_s, sd_p;
    logic lsb, asc, rdbuf, upd_pend, upd;
    dpscp_sph_t sph;
    dpscp_ist_t ist;
    logic [4:0] cnt;
    logic [15:0] sr;
    logic rw;
    logic [1:0] ibyte;
    logic [15:0] addr;
    logic [15:0] rd_addr;
    logic rd_req, rd_ld;
    logic [7:0] tx;
    logic oe, sdo;
    logic wv;
    dpscp_wr_t wd;
  } dpscp_st_t;
endpackage

// ### testbench/dpscp_host_model.sv
// Behavioural serial master for the control port, three-wire or two-wire
`timescale 1ns/100ps
module dpscp_host_model (
  input wire logic i_dev_sd,
  input wire logic i_dev_oe,
  output logic o_sclk,
  output logic o_cs_n,
  output logic o_sdio
);
  logic i2c = 1'b0;
  logic lsb = 1'b0;
  logic en = 1'b0;
  logic sd = 1'b1;
  logic junk = 1'b0;
  logic [7:0] wq[$];
  logic [7:0] rq[$];
  // ********
  // Wire level
  // ********
  // An undriven three-wire line toggles every 37 ns, so a stale bit reads back as good only by chance
  always #37 junk = ~junk;
  assign o_sdio = i2c ? ((i_dev_oe ? i_dev_sd : 1'b1) & sd) : (i_dev_oe ? i_dev_sd : (en ? sd : junk));
  initial begin
    o_sclk = 1'b0;
    o_cs_n = 1'b1;
  end
  task set_i2c();
    i2c = 1'b1;
    sd = 1'b1;
    o_sclk = 1'b1;
  endtask
  task spi_bit(input logic b, input logic rd, output logic got);
    if (!rd) sd = b;
    #100;
    got = o_sdio;
    o_sclk = 1'b1;
    #100;
    o_sclk = 1'b0;
  endtask
  task spi_cmd(input logic rw, input logic [14:0] a, input int n);
    logic [15:0] w;
    logic [7:0] v;
    logic g;
    w = {rw, a};
    o_cs_n = 1'b0;
    en = 1'b1;
    for (int i = 0; i < 16; i++) spi_bit(lsb ? w[i] : w[15-i], 1'b0, g);
    en = !rw;
    for (int k = 0; k < n; k++) begin
      v = rw ? 8'h00 : wq.pop_front();
      for (int i = 0; i < 8; i++) begin
        spi_bit(v[lsb ? i : 7-i], rw, g);
        if (rw) v[lsb ? i : 7-i] = g;
      end
      if (rw) rq.push_back(v);
    end
    #100;
    o_cs_n = 1'b1;
    en = 1'b0;
    #300;
  endtask
  task i2c_bit(input logic b, output logic got);
    sd = b;
    #60;
    o_sclk = 1'b1;
    #80;
    got = o_sdio;
    o_sclk = 1'b0;
    #60;
  endtask
  task i2c_start();
    if (!o_sclk) begin
      sd = 1'b1;
      #60;
      o_sclk = 1'b1;
    end
    #100;
    sd = 1'b0;
    #100;
    o_sclk = 1'b0;
    #60;
  endtask
  task i2c_stop();
    sd = 1'b0;
    #60;
    o_sclk = 1'b1;
    #100;
    sd = 1'b1;
    #200;
  endtask
  task i2c_wr(input logic [7:0] v, output logic ack);
    logic g;
    for (int i = 7; i >= 0; i--) i2c_bit(v[i], g);
    i2c_bit(1'b1, ack);
  endtask
  task i2c_rd(input logic last, output logic [7:0] v);
    logic g;
    for (int i = 7; i >= 0; i--) i2c_bit(1'b1, v[i]);
    i2c_bit(last, g);
  endtask
endmodule

// ### testbench/dpscp_port_tb.sv
// Self-checking bench for the dual protocol serial control port
`timescale 1ns/100ps
module dpscp_port_tb
  import dpscp_pkg::*;
;
  logic core_clk = 1'b0;
  logic reset = 1'b1;
  logic [1:0] sp0 = 2'h1;
  logic [1:0] sp1 = 2'h1;
  logic wr_ready = 1'b0;
  logic [7:0] rd_act = 8'h00;
  logic [7:0] rd_buf = 8'h00;
  logic sclk, cs_n, sdio, dev_sd, dev_oe, spi_mode, wr_valid, rd_req, io_update, ack;
  dpscp_wr_t wr;
  logic [15:0] rd_addr;
  logic [7:0] rb;
  logic [7:0] seq [8] = '{8'h72, 8'h01, 8'h00, 8'h11, 8'h22, 8'h72, 8'h01, 8'h02};
  int miscompares = 0;
  int samples_checked = 0;
  int upd_seen = 0;
  int i;

  always #12.5 core_clk = ~core_clk;
  // Register file stand-in: distinct contents for active and buffered copies
  always_ff @(posedge core_clk) begin
    rd_act <= rd_addr[7:0] ^ 8'h5A;
    rd_buf <= rd_addr[7:0] + 8'h01;
  end
  // Update is a one-cycle pulse that can end before the write task returns
  always @(posedge core_clk) begin
    if (io_update === 1'b1) upd_seen <= upd_seen + 1;
  end

  dpscp_port u_dut (.i_core_clk(core_clk), .i_reset(reset), .i_clk_en(1'b1), .i_port_select_pin_0(sp0),
    .i_port_select_pin_1(sp1), .i_sclk(sclk), .i_cs_n(cs_n), .i_sdio(sdio), .o_sdio(dev_sd),
    .o_sdio_oe(dev_oe), .o_spi_mode(spi_mode), .o_wr_valid(wr_valid), .i_wr_ready(wr_ready), .o_wr(wr),
    .o_rd_req(rd_req), .o_rd_addr(rd_addr), .i_rd_buf_data(rd_buf), .i_rd_act_data(rd_act),
    .o_io_update(io_update));
  dpscp_host_model u_host (.i_dev_sd(dev_sd), .i_dev_oe(dev_oe), .o_sclk(sclk), .o_cs_n(cs_n), .o_sdio(sdio));

  // ********
  // Checks and bus tasks
  // ********
  task chk1(input string n, input logic e, input logic g);
    samples_checked++;
    if (g !== e) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask
  task chk8(input string n, input logic [7:0] e, input logic [7:0] g);
    samples_checked++;
    if (g !== e) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask
  task chkw(input string n, input dpscp_wr_t e, input dpscp_wr_t g);
    samples_checked++;
    if (g !== e) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask
  task stop_test();
    if (miscompares == 0 && samples_checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task pop(input logic [15:0] a, input logic [7:0] d);
    int k;
    for (k = 0; k < 200; k++) begin
      @(negedge core_clk);
      if (wr_valid === 1'b1) break;
    end
    if (k == 200) begin
      miscompares++;
      stop_test();
    end
    chkw("write entry", {a, d}, wr);
    @(posedge core_clk) wr_ready <= 1'b1;
    @(posedge core_clk) wr_ready <= 1'b0;
  endtask
  task spi_wr1(input logic [14:0] a, input logic [7:0] d);
    u_host.wq.push_back(d);
    u_host.spi_cmd(1'b0, a, 1);
  endtask
  // Straps only count at release, so they change together with reset
  task do_reset(input logic [1:0] p0, input logic [1:0] p1);
    @(posedge core_clk);
    sp0 <= p0;
    sp1 <= p1;
    reset <= 1'b1;
    repeat (2) @(posedge core_clk);
    reset <= 1'b0;
    repeat (10) @(posedge core_clk);
  endtask

  // ********
  // Main sequence
  // ********
  initial begin
    do_reset(2'h1, 2'h1);
    @(negedge core_clk);
    chk1("spi mode", 1'b1, spi_mode);
    u_host.wq.push_back(8'hA5);
    u_host.wq.push_back(8'h3C);
    u_host.spi_cmd(1'b0, 15'h0123, 2);
    pop(16'h0123, 8'hA5);
    pop(16'h0122, 8'h3C);
    u_host.spi_cmd(1'b1, 15'h0040, 2);
    chk8("read byte 0", 8'h1A, u_host.rq.pop_front());
    chk8("read byte 1", 8'h65, u_host.rq.pop_front());
    @(negedge core_clk);
    chk1("sdio oe", 1'b0, dev_oe);
    spi_wr1(15'h0001, 8'h20);
    u_host.spi_cmd(1'b1, 15'h0050, 1);
    chk8("buffered read", 8'h51, u_host.rq.pop_front());
    spi_wr1(15'h0000, 8'h24);
    u_host.spi_cmd(1'b1, 15'h0060, 2);
    chk8("ascending read 0", 8'h61, u_host.rq.pop_front());
    chk8("ascending read 1", 8'h62, u_host.rq.pop_front());
    for (i = 0; i < 10; i++) u_host.wq.push_back(8'h30 + 8'(i));
    u_host.spi_cmd(1'b0, 15'h0010, 10);
    for (i = 0; i < 8; i++) pop(16'h0010 + 16'(i), 8'h30 + 8'(i));
    @(negedge core_clk);
    chk1("fifo empty", 1'b0, wr_valid);
    spi_wr1(15'h000F, 8'h01);
    repeat (4) @(negedge core_clk);
    chk1("io update pulse", 1'b1, upd_seen == 1);
    chk1("io update", 1'b0, io_update);
    spi_wr1(15'h0000, 8'h66);
    u_host.lsb = 1'b1;
    spi_wr1(15'h0020, 8'h12);
    pop(16'h0020, 8'h12);
    u_host.spi_cmd(1'b1, 15'h0030, 1);
    chk8("lsb read", 8'h31, u_host.rq.pop_front());
    u_host.set_i2c();
    do_reset(2'h2, 2'h0);
    @(negedge core_clk);
    chk1("spi mode", 1'b0, spi_mode);
    u_host.i2c_start();
    u_host.i2c_wr(8'h74, ack);
    chk1("foreign ack", 1'b1, ack);
    u_host.i2c_stop();
    u_host.i2c_start();
    for (i = 0; i < 5; i++) begin
      u_host.i2c_wr(seq[i], ack);
      chk1("write ack", 1'b0, ack);
    end
    u_host.i2c_stop();
    pop(16'h0100, 8'h11);
    pop(16'h0101, 8'h22);
    u_host.i2c_start();
    for (i = 5; i < 8; i++) u_host.i2c_wr(seq[i], ack);
    for (i = 0; i < 3; i++) u_host.i2c_bit(1'b1, ack);
    u_host.i2c_start();
    u_host.i2c_wr(8'h73, ack);
    chk1("read ack", 1'b0, ack);
    u_host.i2c_rd(1'b0, rb);
    chk8("i2c byte 0", 8'h58, rb);
    u_host.i2c_rd(1'b1, rb);
    chk8("i2c byte 1", 8'h59, rb);
    u_host.i2c_stop();
    @(negedge core_clk);
    chk1("sda oe", 1'b0, dev_oe);
    chk1("fifo empty", 1'b0, wr_valid);
    stop_test();
  end
endmodule
